// file: design/pdm_bridge_defines.svh
// constants for the three-channel pdm bridge driver
// assumes a single drive clock; included by both module files
`ifndef PDM_BRIDGE_DEFINES_SVH
`define PDM_BRIDGE_DEFINES_SVH

// ==========================================================
// phase counter
`define PDM_PHASE_W      2
`define PDM_PHASE_LAST   2'h3
`define PDM_PHASE_STEP   2'h1
`define PDM_TRIG_LAG     2'h1

// ==========================================================
// channel indices, also the sampling phase of each channel
`define CH_SLEDGE        2'h0
`define CH_FOCUS         2'h1
`define CH_RADIAL        2'h2
`define CH_COUNT         3

// ==========================================================
// pin synchroniser bit positions: three data, two enables
`define SYNC_W           5
`define SYNC_EN_A        3
`define SYNC_EN_B        4

`endif

// file: design/pdm_bridge_pkg.sv
// types and decode functions for the pdm bridge driver
// no state; used through package::name only
package pdm_bridge_pkg;

   // ==========================================================
   // switch pattern of one bridge, one-hot
   typedef enum logic [3:0] {
      DRV_OPEN  = 4'h1,
      DRV_POS   = 4'h2,
      DRV_NEG   = 4'h4,
      DRV_SHORT = 4'h8
   } drive_t;

   // operating modes from the enable pair, one-hot
   typedef enum logic [3:0] {
      MODE_STANDBY   = 4'h1,
      MODE_PARTLY    = 4'h2,
      MODE_RESET     = 4'h4,
      MODE_OPERATING = 4'h8
   } mode_t;

   // ==========================================================
   // notch: zero at half the sample rate, three-level result
   function automatic drive_t notch(input logic cur, input logic prev);
      if (cur != prev) begin
         notch = DRV_SHORT;
      end else if (cur) begin
         notch = DRV_POS;
      end else begin
         notch = DRV_NEG;
      end
   endfunction

   function automatic mode_t decode_mode(input logic selA, input logic selB);
      case ({selA, selB})
         2'b00:   decode_mode = MODE_STANDBY;
         2'b01:   decode_mode = MODE_PARTLY;
         2'b10:   decode_mode = MODE_RESET;
         default: decode_mode = MODE_OPERATING;
      endcase
   endfunction

endpackage

// file: design/bridge_channel.sv
// one h-bridge: switch state updated on falling clock edges
// assumes trigger and drive request come from rising-edge logic
`timescale 1ns/1ps
`default_nettype none
`include "pdm_bridge_defines.svh"

module bridge_channel (
   input  wire logic                    mclk,     // drive clock
   input  wire logic                    rst_n,    // synchronous reset
   input  wire logic                    trig,     // output trigger strobe
   input  wire logic                    enable,   // driver on
   input  wire pdm_bridge_pkg::drive_t  request,  // filtered pattern
   output logic                         posVal,   // positive pin level
   output logic                         posOe,    // positive pin driven
   output logic                         negVal,   // negative pin level
   output logic                         negOe     // negative pin driven
);

   typedef struct packed {
      pdm_bridge_pkg::drive_t cur;
   } chan_state_t;

   chan_state_t st_r;
   chan_state_t st_nxt;
   pdm_bridge_pkg::drive_t tgt;

   // ==========================================================
   // next state
   always_comb begin
      st_nxt = st_r;
      tgt    = enable ? request : pdm_bridge_pkg::DRV_OPEN;
      if (trig) begin
         // a change between two closed patterns opens the bridge until its own next
         // trigger: every switching stays on this bridge's phase, at the cost of
         // one open sample period per change between closed patterns
         if (tgt != st_r.cur && st_r.cur != pdm_bridge_pkg::DRV_OPEN) begin
            st_nxt.cur = pdm_bridge_pkg::DRV_OPEN;
         end else begin
            st_nxt.cur = tgt;
         end
      end
   end

   // falling edge keeps output switching away from input sampling
   always_ff @(negedge mclk) begin
      if (!rst_n) begin
         st_r.cur <= pdm_bridge_pkg::DRV_OPEN;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ==========================================================
   // switches: a pos-high, b neg-high, c pos-low, d neg-low
   always_comb begin
      posVal = (st_r.cur == pdm_bridge_pkg::DRV_POS);
      negVal = (st_r.cur == pdm_bridge_pkg::DRV_NEG);
      posOe  = (st_r.cur != pdm_bridge_pkg::DRV_OPEN);
      negOe  = (st_r.cur != pdm_bridge_pkg::DRV_OPEN);
   end

   // ==========================================================
   a_no_direct_swap: assert property (@(negedge mclk) disable iff (!rst_n)
      ($past(st_r.cur) != pdm_bridge_pkg::DRV_OPEN && st_r.cur != pdm_bridge_pkg::DRV_OPEN)
      |-> st_r.cur == $past(st_r.cur))
      else $error("bridge moved between closed patterns without open gap");
   a_trig_applies: assert property (@(negedge mclk) disable iff (!rst_n)
      (trig && !enable) |=> st_r.cur == pdm_bridge_pkg::DRV_OPEN)
      else $error("disabled bridge not opened at trigger");
   a_open_lands: assert property (@(negedge mclk) disable iff (!rst_n)
      (trig && enable && st_r.cur == pdm_bridge_pkg::DRV_OPEN) |=> st_r.cur == $past(request))
      else $error("open bridge did not take the requested pattern at trigger");
   a_hold_off_trig: assert property (@(negedge mclk) disable iff (!rst_n)
      !trig |=> $stable(st_r.cur))
      else $error("bridge switched on another bridge's phase");

endmodule
`default_nettype wire

// file: design/pdm_bridge_driver_timing.sv
// pdm bridge driver: samples three pdm streams and drives three bridges
// assumes pins are asynchronous to mclk except the radial float pin,
// which acts without any clock
`timescale 1ns/1ps
`default_nettype none
`include "pdm_bridge_defines.svh"

module pdm_bridge_driver_timing (
   input  wire logic mclk,            // drive clock
   input  wire logic rst_n,           // synchronous reset
   input  wire logic sledgePdmIn,     // sledge pdm data pin
   input  wire logic focusPdmIn,      // focus pdm data pin
   input  wire logic radialPdmIn,     // radial pdm data pin
   input  wire logic enableSelectA,   // first enable pin
   input  wire logic enableSelectB,   // second enable pin
   input  wire logic radialFloat,     // radial high-impedance pin
   output logic      sledgeOutPos,    // sledge positive level
   output logic      sledgeOutPosOe,  // sledge positive driven
   output logic      sledgeOutNeg,    // sledge negative level
   output logic      sledgeOutNegOe,  // sledge negative driven
   output logic      focusOutPos,     // focus positive level
   output logic      focusOutPosOe,   // focus positive driven
   output logic      focusOutNeg,     // focus negative level
   output logic      focusOutNegOe,   // focus negative driven
   output logic      radialOutPos,    // radial positive level
   output logic      radialOutPosOe,  // radial positive driven
   output logic      radialOutNeg,    // radial negative level
   output logic      radialOutNegOe   // radial negative driven
);

   typedef struct packed {
      logic [`PDM_PHASE_W-1:0] phase;
      logic [`SYNC_W-1:0]      sync1;
      logic [`SYNC_W-1:0]      sync2;
      logic [`CH_COUNT-1:0]    sample;
      logic [`CH_COUNT-1:0]    prev;
      pdm_bridge_pkg::mode_t   mode;
   } top_state_t;

   top_state_t                st_r;
   top_state_t                st_nxt;
   logic [`CH_COUNT-1:0]      sampleStrobe;
   logic [`CH_COUNT-1:0]      outputTrigger;
   logic [`CH_COUNT-1:0]      driverOn;
   pdm_bridge_pkg::drive_t    req [`CH_COUNT];
   logic                      radPosOe;
   logic                      radNegOe;

   // ==========================================================
   // strobes from the phase counter
   always_comb begin
      for (int k = 0; k < `CH_COUNT; k++) begin
         sampleStrobe[k]  = (st_r.phase == 2'(k));
         // each trigger lags its sample so phase 0 never switches a bridge
         outputTrigger[k] = (st_r.phase == 2'(k) + `PDM_TRIG_LAG);
      end
   end

   // ==========================================================
   // mode decode
   always_comb begin
      driverOn[`CH_SLEDGE] = (st_r.mode == pdm_bridge_pkg::MODE_OPERATING);
      driverOn[`CH_FOCUS]  = (st_r.mode == pdm_bridge_pkg::MODE_OPERATING) ||
                             (st_r.mode == pdm_bridge_pkg::MODE_PARTLY);
      driverOn[`CH_RADIAL] = driverOn[`CH_FOCUS];
      for (int k = 0; k < `CH_COUNT; k++) begin
         req[k] = pdm_bridge_pkg::notch(st_r.sample[k], st_r.prev[k]);
      end
   end

   // ==========================================================
   // next state
   always_comb begin
      st_nxt       = st_r;
      st_nxt.phase = st_r.phase + `PDM_PHASE_STEP;
      st_nxt.sync1 = {enableSelectB, enableSelectA, radialPdmIn, focusPdmIn, sledgePdmIn};
      st_nxt.sync2 = st_r.sync1;
      // mode only follows the pins while the clock runs
      st_nxt.mode  = pdm_bridge_pkg::decode_mode(st_r.sync2[`SYNC_EN_A],
                                                 st_r.sync2[`SYNC_EN_B]);
      for (int k = 0; k < `CH_COUNT; k++) begin
         if (sampleStrobe[k]) begin
            st_nxt.prev[k]   = st_r.sample[k];
            st_nxt.sample[k] = st_r.sync2[k];
         end
      end
      if (st_r.mode == pdm_bridge_pkg::MODE_RESET) begin
         st_nxt.sample = '0;
         st_nxt.prev   = '0;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         st_r.phase  <= '0;
         st_r.sync1  <= '0;
         st_r.sync2  <= '0;
         st_r.sample <= '0;
         st_r.prev   <= '0;
         st_r.mode   <= pdm_bridge_pkg::MODE_STANDBY;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ==========================================================
   // bridges
   bridge_channel u_sledge (
      .mclk    (mclk),
      .rst_n   (rst_n),
      .trig    (outputTrigger[`CH_SLEDGE]),
      .enable  (driverOn[`CH_SLEDGE]),
      .request (req[`CH_SLEDGE]),
      .posVal  (sledgeOutPos),
      .posOe   (sledgeOutPosOe),
      .negVal  (sledgeOutNeg),
      .negOe   (sledgeOutNegOe)
   );

   bridge_channel u_focus (
      .mclk    (mclk),
      .rst_n   (rst_n),
      .trig    (outputTrigger[`CH_FOCUS]),
      .enable  (driverOn[`CH_FOCUS]),
      .request (req[`CH_FOCUS]),
      .posVal  (focusOutPos),
      .posOe   (focusOutPosOe),
      .negVal  (focusOutNeg),
      .negOe   (focusOutNegOe)
   );

   bridge_channel u_radial (
      .mclk    (mclk),
      .rst_n   (rst_n),
      .trig    (outputTrigger[`CH_RADIAL]),
      .enable  (driverOn[`CH_RADIAL]),
      .request (req[`CH_RADIAL]),
      .posVal  (radialOutPos),
      .posOe   (radPosOe),
      .negVal  (radialOutNeg),
      .negOe   (radNegOe)
   );

   // ==========================================================
   // radial float gate: pure logic, no flip-flop, so it works with the clock stopped;
   // the pad carries the pull-down, an open pin reads low here
   always_comb begin
      radialOutPosOe = radPosOe && !radialFloat;
      radialOutNegOe = radNegOe && !radialFloat;
   end

   // ==========================================================
   a_float_opens: assert property (@(posedge mclk) disable iff (!rst_n)
      radialFloat |-> (!radialOutPosOe && !radialOutNegOe))
      else $error("radial bridge driven while float input high");
   a_phase_counts: assert property (@(posedge mclk) disable iff (!rst_n)
      $past(rst_n) |-> st_r.phase == $past(st_r.phase) + `PDM_PHASE_STEP)
      else $error("phase counter did not advance by one");
   a_spare_edge: assert property (@(posedge mclk) disable iff (!rst_n)
      (st_r.phase == `PDM_PHASE_LAST) |-> (sampleStrobe == '0) ##1 $onehot(sampleStrobe))
      else $error("spare phase sampled or next phase idle");
   a_no_trig_phase0: assert property (@(posedge mclk) disable iff (!rst_n)
      (st_r.phase == 2'h0) |-> (outputTrigger == '0) ##1 outputTrigger[`CH_SLEDGE])
      else $error("trigger pattern wrong around phase zero");
   a_sample_held: assert property (@(posedge mclk) disable iff (!rst_n)
      (!$past(sampleStrobe[`CH_FOCUS]) && st_r.mode != pdm_bridge_pkg::MODE_RESET
       && $past(st_r.mode) != pdm_bridge_pkg::MODE_RESET)
      |-> $stable(st_r.sample[`CH_FOCUS]))
      else $error("focus sample changed off its strobe");
   a_sledge_mode: assert property (@(posedge mclk) disable iff (!rst_n)
      driverOn[`CH_SLEDGE] |-> ($past(st_r.sync2[`SYNC_EN_A]) && $past(st_r.sync2[`SYNC_EN_B])))
      else $error("sledge enabled without both enables");
   a_idle_short: assert property (@(posedge mclk) disable iff (!rst_n)
      (st_r.sample[`CH_RADIAL] != st_r.prev[`CH_RADIAL])
      |-> req[`CH_RADIAL] == pdm_bridge_pkg::DRV_SHORT)
      else $error("alternating samples not filtered to short");
   a_one_positive: assert property (@(posedge mclk) disable iff (!rst_n)
      (st_r.sample[`CH_SLEDGE] && st_r.prev[`CH_SLEDGE])
      |-> req[`CH_SLEDGE] == pdm_bridge_pkg::DRV_POS)
      else $error("two ones did not request positive drive");

   // phase, strobe, mode and filter checks
   a_one_trigger: assert property (@(posedge mclk) disable iff (!rst_n)
      $onehot0(outputTrigger))
      else $error("two bridges triggered in one phase");
   a_one_strobe: assert property (@(posedge mclk) disable iff (!rst_n)
      $onehot0(sampleStrobe))
      else $error("two channels sampled on one edge");
   a_sample_takes: assert property (@(posedge mclk) disable iff (!rst_n)
      ($past(sampleStrobe[`CH_RADIAL]) && $past(st_r.mode) != pdm_bridge_pkg::MODE_RESET)
      |-> st_r.sample[`CH_RADIAL] == $past(st_r.sync2[`CH_RADIAL]))
      else $error("radial sample did not take the synchronised pin");
   a_reset_clears: assert property (@(posedge mclk) disable iff (!rst_n)
      ($past(st_r.mode) == pdm_bridge_pkg::MODE_RESET)
      |-> (st_r.sample == '0 && st_r.prev == '0))
      else $error("reset mode left filter history set");
   a_focus_mode: assert property (@(posedge mclk) disable iff (!rst_n)
      driverOn[`CH_FOCUS] |-> $past(st_r.sync2[`SYNC_EN_B]))
      else $error("focus enabled without second enable");
   a_zero_negative: assert property (@(posedge mclk) disable iff (!rst_n)
      (!st_r.sample[`CH_FOCUS] && !st_r.prev[`CH_FOCUS])
      |-> req[`CH_FOCUS] == pdm_bridge_pkg::DRV_NEG)
      else $error("two zeros did not request negative drive");

endmodule
`default_nettype wire

// file: tb/pdm_source_model.sv
// servo controller stand-in: three pdm bit streams
// assumes mclk runs free; the bench picks a pattern per channel
`timescale 1ns/1ps
`default_nettype none

module pdm_source_model (
   input  wire logic       mclk,    // drive clock
   input  wire logic [5:0] pat,     // two bits a channel, sledge lowest
   output logic            sledge,  // sledge pdm bit
   output logic            focus,   // focus pdm bit
   output logic            radial   // radial pdm bit
);
   // ==========================================================
   // patterns: 0 zeros, 1 ones, 2 idle, 3 toggle every two clocks
   logic [2:0] cnt;

   function automatic logic pick(input logic [1:0] p, input logic [2:0] c);
      case (p)
         2'h0:    pick = 1'b0;
         2'h1:    pick = 1'b1;
         2'h2:    pick = c[2]; // flips once a sample period
         default: pick = c[1]; // faster than the sample rate on purpose
      endcase
   endfunction

   initial begin
      cnt = 3'h0;
      sledge = 1'b0;
      focus = 1'b0;
      radial = 1'b0;
   end

   always @(posedge mclk) begin
      cnt <= cnt + 3'h1;
      #1;
      sledge = pick(pat[1:0], cnt);
      focus = pick(pat[3:2], cnt);
      radial = pick(pat[5:4], cnt);
   end
endmodule

`default_nettype wire

// file: tb/tb_top.sv
// self-checking bench for the pdm bridge driver
// assumes the source model drives the pdm pins; the bench owns the rest
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   // ==========================================================
   // stimulus and observation
   localparam logic [3:0] POS = 4'he;
   localparam logic [3:0] NEG = 4'hb;
   localparam logic [3:0] SHT = 4'ha;
   localparam logic [3:0] OFF = 4'h0;
   logic       mclk;
   logic       rst_n;
   logic       enA;
   logic       enB;
   logic       floatDrv;
   logic [5:0] pat;
   logic       monOn;
   logic       raOn;
   logic [3:0] seen [3];
   int         badCount;
   int         cmpCount;
   int         cycles;
   wire logic  slPin, foPin, raPin;
   wire logic  sP, sPo, sN, sNo, fP, fPo, fN, fNo, rP, rPo, rN, rNo;
   wire logic [3:0] sNow [3];

   // pin state {posOe, pos, negOe, neg}, undriven levels masked
   assign sNow[0] = {sPo, sPo & sP, sNo, sNo & sN};
   assign sNow[1] = {fPo, fPo & fP, fNo, fNo & fN};
   assign sNow[2] = {rPo, rPo & rP, rNo, rNo & rN};

   always #5 mclk = ~mclk;

   pdm_source_model u_pdm_source_model (.mclk(mclk), .pat(pat), .sledge(slPin),
      .focus(foPin), .radial(raPin));

   pdm_bridge_driver_timing u_pdm_bridge_driver_timing (.mclk(mclk), .rst_n(rst_n),
      .sledgePdmIn(slPin), .focusPdmIn(foPin), .radialPdmIn(raPin),
      .enableSelectA(enA), .enableSelectB(enB), .radialFloat(floatDrv),
      .sledgeOutPos(sP), .sledgeOutPosOe(sPo), .sledgeOutNeg(sN), .sledgeOutNegOe(sNo),
      .focusOutPos(fP), .focusOutPosOe(fPo), .focusOutNeg(fN), .focusOutNegOe(fNo),
      .radialOutPos(rP), .radialOutPosOe(rPo), .radialOutNeg(rN), .radialOutNegOe(rNo));

   // ==========================================================
   // shared tasks
   task automatic check(input logic [3:0] got, input logic [3:0] exp);
      cmpCount++;
      if (got !== exp) begin
         badCount++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask

   task automatic wrapUp();
      $display("comparisons %0d mismatches %0d", cmpCount, badCount);
      if (badCount == 0 && cmpCount > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // ==========================================================
   // monitors: switching only on falling edges, one bridge at a time
   always @(negedge mclk) begin
      int n;
      #1;
      n = 0;
      for (int k = 0; k < 3; k++) begin
         if (monOn && (k < 2 || raOn) && sNow[k] !== seen[k]) begin
            n++;
            check({3'h0, seen[k] != OFF && sNow[k] != OFF}, 4'h0);
         end
         seen[k] = sNow[k];
      end
      check({3'h0, n > 1}, 4'h0);
   end

   always @(posedge mclk) begin
      #2;
      for (int k = 0; k < 3; k++) begin
         if (monOn && (k < 2 || raOn)) begin
            check(sNow[k], seen[k]);
         end
      end
   end

   always @(posedge mclk) begin
      cycles++;
      if (cycles == 2000) begin
         badCount++;
         $display("BAD t=%0t got=%h exp=%h", $time, cycles, 2000);
         wrapUp();
      end
   end

   // ==========================================================
   // scenarios
   task automatic tModes();
      for (int m = 0; m < 4; m++) begin
         {enA, enB} = m[1:0]; // clock keeps running across the change
         pat = 6'h11;
         settle(32);
         check(sNow[0], (m == 3) ? POS : OFF);
         check(sNow[1], m[0] ? NEG : OFF);
         check(sNow[2], m[0] ? POS : OFF);
      end
      $display("modes test done");
   endtask

   task automatic tIdle();
      logic [3:0] exp [3];
      logic [5:0] pats [3];
      exp = '{SHT, NEG, POS};
      pats = '{6'h2a, 6'h00, 6'h15};
      for (int i = 0; i < 3; i++) begin
         pat = pats[i];
         settle(40);
         for (int k = 0; k < 3; k++) begin
            check(sNow[k], exp[i]);
         end
      end
      $display("notch test done");
   endtask

   task automatic tRate();
      pat = 6'h3f;
      repeat (2) begin
         settle(29);
         // sledge and radial are taken two clocks apart, so always opposite
         check({3'h0, (sNow[0] === POS && sNow[2] === NEG) ||
                      (sNow[0] === NEG && sNow[2] === POS)}, 4'h1);
      end
      $display("rate test done");
   endtask

   task automatic tFloat();
      pat = 6'h15;
      settle(32);
      raOn = 1'b0;
      floatDrv = 1'b1;
      #1;
      check(sNow[2], OFF);
      check(sNow[0], POS);
      settle(6);
      check(sNow[2], OFF);
      floatDrv = 1'b0;
      #1;
      check(sNow[2], POS);
      settle(8);
      raOn = 1'b1;
      $display("float test done");
   endtask

   task automatic tReset();
      monOn = 1'b0;
      rst_n = 1'b0;
      settle(3);
      for (int k = 0; k < 3; k++) begin
         check(sNow[k], OFF);
      end
      rst_n = 1'b1;
      settle(40);
      monOn = 1'b1;
      for (int k = 0; k < 3; k++) begin
         check(sNow[k], POS);
      end
      $display("reset test done");
   endtask

   initial begin
      mclk = 1'b0;
      rst_n = 1'b0;
      enA = 1'b0;
      enB = 1'b0;
      floatDrv = 1'b0; // stands in for the pin's pull-down
      pat = 6'h00;
      monOn = 1'b0;
      raOn = 1'b1;
      badCount = 0;
      cmpCount = 0;
      cycles = 0;
      seen = '{OFF, OFF, OFF};
      settle(10);
      rst_n = 1'b1;
      monOn = 1'b1;
      tModes();
      tIdle();
      tRate();
      tFloat();
      tReset();
      wrapUp();
   end
endmodule

`default_nettype wire
